/* File: rtl/acs_pkg.sv */
// Purpose: Shared constants and types for the converter control block
// Assumes: 8-bit offset binary codes, 10-bit signed input levels
// Notes: Counts are in input (sample) clock cycles
`default_nettype none
package acs_pkg;
	localparam int SMP_W = 8;
	localparam int LVL_W = 10;
	localparam int PIPE_DEPTH = 13;
	localparam int TAP_CD = 11;
	localparam int TAP_AB = 12;
	localparam int CAL_CMD_MIN = 80;
	localparam int CMD_CNT_W = 7;
	localparam int DLY_EXP_SHORT = 25;
	localparam int DLY_EXP_LONG = 31;
	localparam int CNT_W = 32;
	localparam logic [CNT_W-1:0] CAL_LEN_DEF = 32'h0000_0578;
	localparam logic signed [LVL_W:0] CODE_OFFSET = 11'sh080;
	localparam logic signed [LVL_W:0] CODE_TOP = 11'sh0FF;
	localparam logic [SMP_W-1:0] CODE_ZERO = 8'h00;
	localparam logic [SMP_W-1:0] CODE_ONES = 8'hFF;
	localparam int CFG_W = 5;
	localparam int PIN_W = 5;

	typedef struct packed {
		logic [SMP_W-1:0] code;
		logic oor;
	} acs_word_t;

	typedef struct packed {
		acs_word_t rise;
		acs_word_t fall;
	} acs_pair_t;

	typedef struct packed {
		logic level;
		logic edge_hi;
		logic ddr;
		logic full_scale;
		logic half_demux;
	} acs_cfg_t;

	typedef enum {ST_DELAY, ST_IDLE, ST_RUN} acs_cal_st_t;
endpackage
`default_nettype wire

/* File: rtl/acs_top.sv */
// Purpose: Calibration sequencing and output formatting of the converter
// Assumes: sample_clk is the input clock, inverted so sampling falls on
//   its rising edge; clk runs the control pin logic
// Notes: Config levels cross domains as quasi-static 2-flop levels
//
// Functional notes
// [R1]: Calibrate once after power-up and again on each valid command.
// [R2]: Command is request low at least 80 cycles, then high 80 cycles.
// [R3]: Request high at power-up blocks calibration until a full command.
// [R4]: Power-up wait is 2^25 cycles, or 2^31 with delay select high.
// [R5]: Power-down holds the power-up delay counter still.
// [R6]: No calibration starts or runs while powered down.
// [R7]: Active flag is high for the whole of any calibration.
// [R8]: Controller must recalibrate after changing the full-scale select.
// [R9]: Controller should calibrate 20 seconds after power and on heat.
// [R10]: Below range gives all zeros, above range gives all ones.
// [R11]: Out-of-range output marks every clamped code.
// [R12]: Results appear 13 cycles later on buses three/four, 14 on one/two.
// [R13]: 1:4 mode uses all buses; 1:2 mode only buses three and four.
// [R14]: Receiver interleaves active buses to rebuild the full-rate stream; acs_capture keeps only every other pair in 1:2 mode.
// [R15]: Output words are offset binary.
// [R16]: Extended mode takes level, edge/rate, full scale from registers.
// [R17]: Controller keeps the control mode fixed while operating.
// [R18]: Running calibration finishes before power-down; commands ignored.
// [R19]: 1:2 selection only acts in double data rate mode.
// [R20]: Power-up calibration starts once at terminal count, flag drops at end.
`default_nettype none
module acs_top
	import acs_pkg::*;
#(
	parameter logic [CNT_W-1:0] DLY_SHORT_CYC = CNT_W'(1) << DLY_EXP_SHORT,
	parameter logic [CNT_W-1:0] DLY_LONG_CYC = CNT_W'(1) << DLY_EXP_LONG,
	parameter logic [CNT_W-1:0] CAL_CYC = CAL_LEN_DEF
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sample_clk,
	input wire logic cal_request_pin,
	input wire logic power_down_pin,
	input wire logic cal_delay_select,
	input wire logic ext_control_en,
	input wire logic output_level_select,
	input wire logic output_edge_select,
	input wire logic ddr_select,
	input wire logic full_scale_select,
	input wire logic cfg_output_level,
	input wire logic cfg_output_edge,
	input wire logic cfg_ddr,
	input wire logic cfg_full_scale,
	input wire logic cfg_demux_half,
	input wire logic signed [LVL_W-1:0] sample_level_rise,
	input wire logic signed [LVL_W-1:0] sample_level_fall,
	output logic cal_active_flag,
	output logic power_down_active,
	output logic output_enable,
	output logic out_of_range,
	output logic [SMP_W-1:0] sample_bus_one,
	output logic [SMP_W-1:0] sample_bus_two,
	output logic [SMP_W-1:0] sample_bus_three,
	output logic [SMP_W-1:0] sample_bus_four,
	output logic forwarded_output_clock,
	output logic output_level_eff,
	output logic full_scale_eff
);

	// Offset binary clamp of a signed level
	function automatic acs_word_t clamp_level(
		input logic signed [LVL_W-1:0] lvl);
		logic signed [LVL_W:0] sum;
		acs_word_t w;
		sum = 11'(lvl) + CODE_OFFSET; // [R15]
		if (sum < 0) begin
			w = '{code: CODE_ZERO, oor: 1'b1}; // [R10] [R11]
		end else if (sum > CODE_TOP) begin
			w = '{code: CODE_ONES, oor: 1'b1}; // [R10] [R11]
		end else begin
			w = '{code: sum[SMP_W-1:0], oor: 1'b0};
		end
		return w;
	endfunction

	// Control pin domain
	logic [PIN_W-1:0] pin_a_r;
	logic [PIN_W-1:0] pin_b_r;
	acs_cfg_t eff_r;
	acs_cfg_t eff_nxt;
	logic ext_s;
	acs_cfg_t pin_cfg;
	acs_cfg_t reg_cfg;

	assign ext_s = pin_b_r[4];
	assign pin_cfg = '{level: pin_b_r[3], edge_hi: pin_b_r[2],
		ddr: pin_b_r[1], full_scale: pin_b_r[0], half_demux: 1'b0};
	assign reg_cfg = '{level: cfg_output_level, edge_hi: cfg_output_edge,
		ddr: cfg_ddr, full_scale: cfg_full_scale,
		half_demux: cfg_demux_half};
	assign eff_nxt = ext_s ? reg_cfg : pin_cfg; // [R16]

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_a_r <= '0;
			pin_b_r <= '0;
			eff_r <= '0;
		end else begin
			pin_a_r <= {ext_control_en, output_level_select,
				output_edge_select, ddr_select, full_scale_select};
			pin_b_r <= pin_a_r;
			eff_r <= eff_nxt;
		end
	end

	assign output_level_eff = eff_r.level;
	assign full_scale_eff = eff_r.full_scale;

	// Sample domain reset: async assert, sync release
	logic [1:0] srst_r;
	logic smp_rst_n;
	assign smp_rst_n = srst_r[1];

	always_ff @(posedge sample_clk or negedge rst_n) begin
		if (!rst_n) begin
			srst_r <= 2'b00;
		end else begin
			srst_r <= {srst_r[0], 1'b1};
		end
	end

	// Pins and config into the sample domain
	localparam int SY_W = CFG_W + 3;
	logic [SY_W-1:0] sy_a_r;
	logic [SY_W-1:0] sy_b_r;
	logic cal_s;
	logic pd_s;
	logic dsel_s;
	acs_cfg_t cfg_s;

	assign cal_s = sy_b_r[SY_W-1];
	assign pd_s = sy_b_r[SY_W-2];
	assign dsel_s = sy_b_r[SY_W-3];
	assign cfg_s = sy_b_r[CFG_W-1:0];

	always_ff @(posedge sample_clk or negedge smp_rst_n) begin
		if (!smp_rst_n) begin
			sy_a_r <= '0;
			sy_b_r <= '0;
		end else begin
			sy_a_r <= {cal_request_pin, power_down_pin, cal_delay_select,
				eff_r};
			sy_b_r <= sy_a_r;
		end
	end

	// Calibration command detector
	logic [CMD_CNT_W-1:0] lo_cnt_r;
	logic [CMD_CNT_W-1:0] hi_cnt_r;
	logic low_seen_r;
	logic cmd_pulse;
	logic lo_full;
	logic hi_full;

	assign lo_full = lo_cnt_r == CMD_CNT_W'(CAL_CMD_MIN - 1);
	assign hi_full = hi_cnt_r == CMD_CNT_W'(CAL_CMD_MIN - 1);
	assign cmd_pulse = cal_s && low_seen_r && hi_full; // [R2]

	always_ff @(posedge sample_clk or negedge smp_rst_n) begin
		if (!smp_rst_n) begin
			lo_cnt_r <= '0;
			hi_cnt_r <= '0;
			low_seen_r <= 1'b0;
		end else begin
			lo_cnt_r <= (cal_s || lo_full) ? '0 : lo_cnt_r + 1'b1;
			hi_cnt_r <= (!cal_s || !low_seen_r || hi_full) ? '0 :
				hi_cnt_r + 1'b1;
			if (!cal_s && lo_full) begin
				low_seen_r <= 1'b1; // [R2]
			end else if (cmd_pulse) begin
				low_seen_r <= 1'b0;
			end
		end
	end

	// Calibration sequencer
	acs_cal_st_t st_r;
	acs_cal_st_t st_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic [2:0] init_r;
	logic blocked_r;
	logic [CNT_W-1:0] dly_term;
	logic dly_done;
	logic run_done;

	// Delay select read live: a change mid-wait moves the terminal count
	assign dly_term = dsel_s ? DLY_LONG_CYC : DLY_SHORT_CYC; // [R4]
	assign dly_done = (st_r == ST_DELAY) && !pd_s && init_r[1] &&
		(cnt_r == dly_term - 1'b1); // [R4] [R5] [R20]
	assign run_done = (st_r == ST_RUN) && (cnt_r == CAL_CYC - 1'b1);

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		unique case (st_r)
			ST_DELAY: begin
				if (dly_done) begin
					cnt_nxt = '0;
					st_nxt = blocked_r ? ST_IDLE : ST_RUN; // [R1] [R3]
				end else if (!pd_s && init_r[1]) begin
					cnt_nxt = cnt_r + 1'b1; // [R5]
				end
			end
			ST_IDLE: begin
				if (cmd_pulse && !pd_s) begin
					st_nxt = ST_RUN; // [R1] [R6] [R18]
					cnt_nxt = '0;
				end
			end
			ST_RUN: begin
				// Power-down is not looked at until the run is over
				cnt_nxt = cnt_r + 1'b1; // [R18]
				if (run_done) begin
					st_nxt = ST_IDLE; // [R20]
					cnt_nxt = '0;
				end
			end
		endcase
	end

	always_ff @(posedge sample_clk or negedge smp_rst_n) begin
		if (!smp_rst_n) begin
			st_r <= ST_DELAY;
			cnt_r <= '0;
			init_r <= 3'b000;
			blocked_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			init_r <= {init_r[1:0], 1'b1};
			// Strap caught once the synchroniser holds valid data
			if (init_r == 3'b011) begin
				blocked_r <= cal_s; // [R3]
			end else if (cmd_pulse) begin
				blocked_r <= 1'b0; // [R3]
			end
		end
	end

	assign cal_active_flag = st_r == ST_RUN; // [R7]
	assign power_down_active = pd_s && (st_r != ST_RUN); // [R18]
	assign output_enable = !power_down_active;

	// Data pipeline
	acs_pair_t pipe_r [PIPE_DEPTH];
	acs_word_t in_rise;
	acs_word_t in_fall;
	assign in_rise = clamp_level(sample_level_rise);
	assign in_fall = clamp_level(sample_level_fall);

	always_ff @(posedge sample_clk or negedge smp_rst_n) begin
		if (!smp_rst_n) begin
			pipe_r[0] <= '0;
		end else begin
			pipe_r[0] <= '{rise: in_rise, fall: in_fall};
		end
	end

	for (genvar g = 1; g < PIPE_DEPTH; g++) begin : g_pipe
		always_ff @(posedge sample_clk or negedge smp_rst_n) begin
			if (!smp_rst_n) begin
				pipe_r[g] <= '0;
			end else begin
				pipe_r[g] <= pipe_r[g-1]; // [R12]
			end
		end
	end

	// Output demultiplexer
	logic phase_r;
	logic half_eff;
	logic upd;
	logic oor_nxt;
	logic fclk_r;
	logic [SMP_W-1:0] bus_one_r;
	logic [SMP_W-1:0] bus_two_r;
	logic [SMP_W-1:0] bus_three_r;
	logic [SMP_W-1:0] bus_four_r;
	logic oor_r;

	assign half_eff = cfg_s.half_demux && cfg_s.ddr; // [R19]
	assign upd = half_eff || phase_r; // [R13]
	assign oor_nxt = pipe_r[TAP_CD].rise.oor || pipe_r[TAP_CD].fall.oor ||
		(!half_eff && (pipe_r[TAP_AB].rise.oor ||
		pipe_r[TAP_AB].fall.oor)); // [R11]

	always_ff @(posedge sample_clk or negedge smp_rst_n) begin
		if (!smp_rst_n) begin
			phase_r <= 1'b0;
			fclk_r <= 1'b0;
			bus_one_r <= '0;
			bus_two_r <= '0;
			bus_three_r <= '0;
			bus_four_r <= '0;
			oor_r <= 1'b0;
		end else begin
			phase_r <= !phase_r;
			fclk_r <= (cfg_s.ddr && !phase_r) ? fclk_r : !fclk_r;
			if (upd) begin
				bus_four_r <= pipe_r[TAP_CD].fall.code; // [R12]
				bus_three_r <= pipe_r[TAP_CD].rise.code; // [R12]
				bus_two_r <= half_eff ? CODE_ZERO :
					pipe_r[TAP_AB].fall.code; // [R12] [R13]
				bus_one_r <= half_eff ? CODE_ZERO :
					pipe_r[TAP_AB].rise.code; // [R12] [R13]
				oor_r <= oor_nxt;
			end
		end
	end

	assign sample_bus_one = bus_one_r;
	assign sample_bus_two = bus_two_r;
	assign sample_bus_three = bus_three_r;
	assign sample_bus_four = bus_four_r;
	assign out_of_range = oor_r;
	// SDR edge choice flips the forwarded clock, not the data
	assign forwarded_output_clock = fclk_r ^ (cfg_s.edge_hi && !cfg_s.ddr);

	// Pipeline holds reset zeros for its depth after reset
	logic [3:0] warm_r;

	always_ff @(posedge sample_clk or negedge smp_rst_n) begin
		if (!smp_rst_n) begin
			warm_r <= '0;
		end else if (warm_r != 4'(PIPE_DEPTH)) begin
			warm_r <= warm_r + 1'b1;
		end
	end

	property p_cmd;
		@(posedge sample_clk) disable iff (!smp_rst_n)
		cmd_pulse |-> $past(cal_s, 79) && low_seen_r;
	endproperty
	a_cmd: assert property (p_cmd) else $error("short command"); // [R2]

	property p_flag;
		@(posedge sample_clk) disable iff (!smp_rst_n)
		(st_r == ST_IDLE && cmd_pulse && !pd_s) |=> cal_active_flag;
	endproperty
	a_flag: assert property (p_flag) else $error("no run on cmd"); // [R7]

	property p_nostart;
		@(posedge sample_clk) disable iff (!smp_rst_n)
		(st_r == ST_IDLE && pd_s) |=> !cal_active_flag;
	endproperty
	a_nostart: assert property (p_nostart) else $error("pd start"); // [R6]

	property p_finish;
		@(posedge sample_clk) disable iff (!smp_rst_n)
		(cal_active_flag && !run_done) |=> cal_active_flag;
	endproperty
	a_finish: assert property (p_finish) else $error("run cut"); // [R18]

	property p_hold;
		@(posedge sample_clk) disable iff (!smp_rst_n)
		(st_r == ST_DELAY && pd_s) |=> $stable(cnt_r);
	endproperty
	a_hold: assert property (p_hold) else $error("delay ran"); // [R5]

	property p_block;
		@(posedge sample_clk) disable iff (!smp_rst_n)
		(dly_done && blocked_r) |=> !cal_active_flag;
	endproperty
	a_block: assert property (p_block) else $error("blocked ran"); // [R3]

	property p_once;
		@(posedge sample_clk) disable iff (!smp_rst_n)
		(dly_done && !blocked_r) |=> cal_active_flag && cnt_r == '0;
	endproperty
	a_once: assert property (p_once) else $error("no pwrup run"); // [R20]

	property p_lat;
		@(posedge sample_clk) disable iff (!smp_rst_n)
		(upd && warm_r == 4'(PIPE_DEPTH)) |=>
			sample_bus_four == $past(in_fall.code, 13);
	endproperty
	a_lat: assert property (p_lat) else $error("latency"); // [R12]

	property p_clamp;
		@(posedge sample_clk) disable iff (!smp_rst_n)
		(sample_level_fall > 10'sh07F) |=>
			pipe_r[0].fall.code == CODE_ONES && pipe_r[0].fall.oor;
	endproperty
	a_clamp: assert property (p_clamp) else $error("clamp"); // [R10] [R11]

	property p_half;
		@(posedge sample_clk) disable iff (!smp_rst_n)
		(upd && half_eff) |=> sample_bus_one == CODE_ZERO;
	endproperty
	a_half: assert property (p_half) else $error("1:2 bus"); // [R13] [R19]

	property p_ext;
		@(posedge clk) disable iff (!rst_n)
		ext_s |=> eff_r.level == $past(cfg_output_level);
	endproperty
	a_ext: assert property (p_ext) else $error("ext mux"); // [R16]

	c_cmd: cover property (@(posedge sample_clk) cmd_pulse);
	c_run: cover property (@(posedge sample_clk) run_done);
	c_oor: cover property (@(posedge sample_clk) out_of_range);
	c_half: cover property (@(posedge sample_clk) half_eff && upd);

endmodule // acs_top
`default_nettype wire

/* File: bench/acs_capture.sv */
// Purpose: Capture device on the far side of the output buses
// Assumes: Buses settle by the falling sample clock edge
// Notes: A word is taken only after the forwarded clock has moved
`default_nettype none
module acs_capture
	import acs_pkg::*;
(
	input wire logic sample_clk,
	input wire logic forwarded_output_clock,
	input wire logic output_enable,
	input wire logic [SMP_W-1:0] bus_one,
	input wire logic [SMP_W-1:0] bus_two,
	input wire logic [SMP_W-1:0] bus_three,
	input wire logic [SMP_W-1:0] bus_four,
	output logic [4*SMP_W-1:0] stream
);
	timeunit 1ns;
	timeprecision 100ps;
	logic last_r = 1'b0;
	initial stream = '0;
	// Rebuilt in sample order one, two, three, four
	always @(negedge sample_clk) begin
		if (output_enable && forwarded_output_clock !== last_r) begin
			stream <= {bus_one, bus_two, bus_three, bus_four};
		end
		last_r <= forwarded_output_clock;
	end
endmodule // acs_capture
`default_nettype wire

/* File: bench/adc_calibration_output_sequencer_bench.sv */
// Purpose: Self-checking bench for calibration and output formatting
// Assumes: Short delay and calibration counts via parameters
// Notes: Levels ramp by one per cycle, so each code shows its age
`default_nettype none
module adc_calibration_output_sequencer_bench
	import acs_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int DS = 64;
	localparam int DL = 128;
	localparam int CL = 20;
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
	err_total++; $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
	logic clk = 0, rst_n = 0, sample_clk = 0, cal_request_pin = 0;
	logic power_down_pin = 0, cal_delay_select = 0, ext_control_en = 0;
	logic output_level_select = 0, output_edge_select = 0, ddr_select = 0;
	logic full_scale_select = 0, cfg_output_level = 0, cfg_output_edge = 0;
	logic cfg_ddr = 0, cfg_full_scale = 0, cfg_demux_half = 0, ramp_on = 0;
	logic signed [LVL_W-1:0] sample_level_rise = '0, sample_level_fall = '0;
	logic cal_active_flag, power_down_active, output_enable, out_of_range;
	logic [SMP_W-1:0] sample_bus_one, sample_bus_two;
	logic [SMP_W-1:0] sample_bus_three, sample_bus_four;
	logic forwarded_output_clock, output_level_eff, full_scale_eff;
	logic [4*SMP_W-1:0] stream;
	logic [SMP_W-1:0] a;
	int err_total = 0, checks = 0, cyc = 0, n = 0, k, lat;
	acs_top #(.DLY_SHORT_CYC(DS), .DLY_LONG_CYC(DL), .CAL_CYC(CL)) dut (
		.clk, .rst_n, .sample_clk, .cal_request_pin, .power_down_pin,
		.cal_delay_select, .ext_control_en, .output_level_select,
		.output_edge_select, .ddr_select, .full_scale_select,
		.cfg_output_level, .cfg_output_edge, .cfg_ddr, .cfg_full_scale,
		.cfg_demux_half, .sample_level_rise, .sample_level_fall,
		.cal_active_flag, .power_down_active, .output_enable, .out_of_range,
		.sample_bus_one, .sample_bus_two, .sample_bus_three,
		.sample_bus_four, .forwarded_output_clock, .output_level_eff,
		.full_scale_eff);
	acs_capture rx (.sample_clk, .forwarded_output_clock, .output_enable,
		.bus_one(sample_bus_one), .bus_two(sample_bus_two),
		.bus_three(sample_bus_three), .bus_four(sample_bus_four), .stream);
	initial forever #5 clk = ~clk;
	initial forever #16 sample_clk = ~sample_clk;
	always @(posedge sample_clk) begin
		if (ramp_on) begin
			n <= n + 1;
			sample_level_rise <= LVL_W'(n - 60);
			sample_level_fall <= LVL_W'(n - 10);
		end
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			conclude();
		end
	end
	task conclude();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task scyc(input int m);
		repeat (m) @(posedge sample_clk);
	endtask
	task cmd(input int lo, input int hi);
		@(posedge sample_clk);
		cal_request_pin <= 1'b0;
		scyc(lo);
		cal_request_pin <= 1'b1;
		scyc(hi);
	endtask
	task wflag(input logic v, input int lim);
		k = 0;
		while (cal_active_flag !== v && k < lim) begin
			@(negedge sample_clk);
			k++;
		end
	endtask
	task ramp(input logic half, input logic ddr);
		@(posedge clk) cfg_ddr <= ddr;
		cfg_demux_half <= half;
		@(posedge sample_clk) n <= 0;
		ramp_on <= 1'b1;
		scyc(40);
		@(negedge sample_clk) a = sample_bus_three;
		lat = n - (int'(a) - 68);
		`CHK("latency", 1'b1, lat >= 14 && lat <= 16)
		`CHK("pair", 8'(a + 8'h32), sample_bus_four)
		`CHK("oor", 1'b0, out_of_range)
		if (half && ddr) begin
			`CHK("one", 8'h00, sample_bus_one)
			@(negedge sample_clk);
			`CHK("step", 8'(a + 8'h01), sample_bus_three)
		end else begin
			`CHK("ab", 8'(sample_bus_one + 8'h01), a)
			`CHK("two", 8'(sample_bus_two + 8'h01), sample_bus_four)
			`CHK("rx", 8'(stream[31:24] + 8'h01), stream[15:8])
		end
		ramp_on <= 1'b0;
	endtask
	initial begin
		// Reset spans several edges of both clocks, as the sync needs
		for (int i = 0; i < 3; i++) begin
			@(posedge sample_clk) rst_n <= 1'b0;
			cal_delay_select <= (i == 1);
			cal_request_pin <= (i == 2);
			power_down_pin <= (i < 2);
			scyc(5);
			rst_n <= 1'b1;
			if (i < 2) begin
				wflag(1'b1, 150);
				`CHK("pd hold", 1'b0, cal_active_flag)
				@(posedge sample_clk) power_down_pin <= 1'b0;
				wflag(1'b1, DL + 40);
				lat = i ? DL : DS;
				`CHK("delay", 1'b1, k >= lat - 1 && k <= lat + 8)
			end else begin
				wflag(1'b1, DS + 40);
				`CHK("strap", 1'b0, cal_active_flag)
				cmd(80, 80);
				wflag(1'b1, 8);
				`CHK("cmd", 1'b1, cal_active_flag)
			end
			wflag(1'b0, CL + 5);
			`CHK("run len", CL, k)
		end
		cmd(78, 100);
		wflag(1'b1, 8);
		`CHK("short low", 1'b0, cal_active_flag)
		cmd(80, 80); // Later recalibration
		wflag(1'b1, 8);
		`CHK("cmd2", 1'b1, cal_active_flag)
		@(posedge sample_clk) power_down_pin <= 1'b1;
		scyc(4);
		`CHK("finish", 1'b0, power_down_active)
		wflag(1'b0, CL + 5);
		scyc(6);
		`CHK("pd", 1'b1, power_down_active)
		`CHK("oe", 1'b0, output_enable)
		cmd(80, 80);
		wflag(1'b1, 30);
		`CHK("pd cmd", 1'b0, cal_active_flag)
		@(posedge sample_clk) power_down_pin <= 1'b0;
		// Pin mode first, then extended mode, which is kept to the end
		for (int e = 0; e < 2; e++) begin
			@(posedge clk) ext_control_en <= e[0];
			output_level_select <= 1'b1;
			full_scale_select <= 1'b1;
			repeat (8) @(posedge clk);
			`CHK("lvl", !e[0], output_level_eff)
			`CHK("fs", !e[0], full_scale_eff)
		end
		cmd(80, 80); // Recalibrate after range change
		wflag(1'b1, 8);
		`CHK("recal", 1'b1, cal_active_flag)
		wflag(1'b0, CL + 20);
		ramp(1'b1, 1'b0);
		ramp(1'b1, 1'b1);
		@(posedge sample_clk) sample_level_rise <= 10'sh0C8;
		sample_level_fall <= -10'sh12C;
		scyc(20);
		@(negedge sample_clk);
		`CHK("high", 8'hFF, sample_bus_three)
		`CHK("low", 8'h00, sample_bus_four)
		`CHK("oor set", 1'b1, out_of_range)
		@(posedge sample_clk) sample_level_rise <= 10'sh000;
		sample_level_fall <= -10'sh001;
		scyc(20);
		@(negedge sample_clk);
		`CHK("mid", 8'h80, sample_bus_three)
		`CHK("mid low", 8'h7F, sample_bus_four)
		conclude();
	end
endmodule // adc_calibration_output_sequencer_bench
`default_nettype wire
